/* File: src/module_flag_interrupt_timing.sv */
// Flag latching, masking, interrupt pin, reset and low-power control of a module.
// Assumes an AXI4-Lite master on aclk; pins arrive asynchronously.
// Operation
// - Management init completes within 2000 ms after power-up or reset release.
// - Interrupt output goes low within 200 ms of a triggering condition.
// - Reading a flag clears it; interrupt releases within 500 us.
// - Receive loss of signal sets its flag and asserts interrupt within 100 ms.
// - Other conditions set their flag and assert interrupt within 200 ms.
// - Setting a mask bit stops its flag driving interrupt within 100 ms.
// - Clearing a mask bit resumes its flag's interrupt within 100 ms.
// - Low-power pin, reset pin or force bit enter low power within 200 us.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module module_flag_interrupt_timing
  import module_flag_pkg::*;
#(
  parameter int unsigned NUM_FLAGS = 8,
  parameter int unsigned INIT_CYCLES = 1024,
  parameter int unsigned INIT_LIMIT_CYCLES = module_flag_pkg::INIT_MAX_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic module_reset_n,
  input wire logic low_power_request_n,
  input wire logic [NUM_FLAGS-1:0] flag_condition,
  output logic module_irq_n,
  output logic management_init_state,
  output logic low_power_mode
);
  import module_flag_pkg::*;

  localparam int unsigned INIT_USED = (INIT_CYCLES < INIT_LIMIT_CYCLES) ? INIT_CYCLES :
                                      INIT_LIMIT_CYCLES;
  localparam logic [31:0] INIT_LAST = 32'(INIT_USED - 1);
  localparam logic [RESET_CNT_W-1:0] RESET_LAST = RESET_CNT_W'(RESET_MIN_CYCLES - 1);

  logic reset_level;
  logic low_power_level;
  logic [NUM_FLAGS-1:0] condition_level;

  pin_sync #(.WIDTH(2), .INIT(2'b11)) u_ctrl_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin({module_reset_n, low_power_request_n}),
    .level({reset_level, low_power_level})
  );

  pin_sync #(.WIDTH(NUM_FLAGS)) u_cond_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin(flag_condition),
    .level(condition_level)
  );

  mgmt_state_type state, next_state;
  logic [31:0] init_count, next_init_count;
  logic [RESET_CNT_W-1:0] reset_count, next_reset_count;
  logic [NUM_FLAGS-1:0] flag, next_flag;
  logic [NUM_FLAGS-1:0] mask, next_mask;
  logic force_low_power_bit, next_force_low_power_bit;
  logic next_module_irq_n;
  logic next_low_power_mode;

  logic aw_held, next_aw_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [NUM_FLAGS-1:0] read_clear;
  logic [NUM_FLAGS-1:0] pending;
  logic [31:0] status_word;

  assign s_axi_awready = clk_en && !aw_held;
  assign s_axi_wready = clk_en && !w_held;
  assign s_axi_arready = clk_en && !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_held && w_held && !bvalid;
  assign pending = flag & ~mask;

  always_comb begin
    status_word = '0;
    status_word[STAT_INIT_BIT] = management_init_state;
    status_word[STAT_LOW_POWER_BIT] = low_power_mode;
    status_word[STAT_IRQ_BIT] = !module_irq_n;
    status_word[STAT_RESET_BIT] = (state == MGMT_RESET);
  end

  // Management state, reset filter and low-power control
  always_comb begin
    next_state = state;
    next_init_count = init_count;
    next_reset_count = reset_count;
    if (reset_level) begin
      next_reset_count = '0;
    end else if (reset_count != RESET_LAST) begin
      next_reset_count = reset_count + RESET_CNT_W'(1);
    end
    unique case (state)
      MGMT_RESET: begin
        if (reset_level) begin
          next_state = MGMT_INIT;
          next_init_count = '0;
        end
      end
      MGMT_INIT: begin
        if (init_count == INIT_LAST) begin
          next_state = MGMT_READY;
        end else begin
          next_init_count = init_count + 32'd1;
        end
      end
      MGMT_READY: begin
      end
    endcase
    // Reset taken after 10 us low
    if (!reset_level && reset_count == RESET_LAST) begin
      next_state = MGMT_RESET;
    end
    next_low_power_mode = force_low_power_bit || !low_power_level || !reset_level ||
                          (next_state == MGMT_RESET);
  end

  // AXI channel capture and register file
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_mask = mask;
    next_force_low_power_bit = force_low_power_bit;
    read_clear = '0;
    if (aw_fire) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case ({aw_addr[7:2], 2'b00})
        MASK_OFFSET: begin
          if (w_strb[0]) begin
            next_mask = w_data[NUM_FLAGS-1:0];
          end
        end
        CONTROL_OFFSET: begin
          if (w_strb[0]) begin
            next_force_low_power_bit = w_data[CTRL_FORCE_LOW_POWER_BIT];
          end
        end
        FLAG_OFFSET, STATUS_OFFSET, CONDITION_OFFSET: begin
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        FLAG_OFFSET: begin
          next_rdata[NUM_FLAGS-1:0] = flag;
          read_clear = flag;
        end
        MASK_OFFSET: next_rdata[NUM_FLAGS-1:0] = mask;
        CONTROL_OFFSET: next_rdata[CTRL_FORCE_LOW_POWER_BIT] = force_low_power_bit;
        STATUS_OFFSET: next_rdata = status_word;
        CONDITION_OFFSET: next_rdata[NUM_FLAGS-1:0] = condition_level;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  // Flag latching and interrupt pin
  always_comb begin
    next_flag = flag & ~read_clear;
    if (state == MGMT_READY) begin
      next_flag = next_flag | condition_level;
    end
    next_module_irq_n = ~|(next_flag & ~next_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= MGMT_INIT;
      init_count <= '0;
      reset_count <= '0;
      flag <= '0;
      mask <= NUM_FLAGS'(MASK_RESET);
      force_low_power_bit <= CONTROL_RESET[CTRL_FORCE_LOW_POWER_BIT];
      module_irq_n <= 1'b1;
      management_init_state <= 1'b1;
      low_power_mode <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (clk_en) begin
      state <= next_state;
      init_count <= next_init_count;
      reset_count <= next_reset_count;
      flag <= next_flag;
      mask <= next_mask;
      force_low_power_bit <= next_force_low_power_bit;
      module_irq_n <= next_module_irq_n;
      management_init_state <= (next_state != MGMT_READY);
      low_power_mode <= next_low_power_mode;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule
`default_nettype wire

/* File: src/module_flag_pkg.sv */
// Constants for the module flag and interrupt block.
// Assumes a single 125 MHz clock and an AXI4-Lite register port.
package module_flag_pkg;
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned CLK_FREQ_MHZ = 125;

  // Timing figures in their own units, then clock counts
  localparam int unsigned INIT_MAX_MS = 2000;
  localparam int unsigned INIT_MAX_CYCLES = INIT_MAX_MS * CLK_FREQ_KHZ;
  localparam int unsigned RESET_MIN_US = 10;
  localparam int unsigned RESET_MIN_CYCLES = RESET_MIN_US * CLK_FREQ_MHZ;
  localparam int unsigned IRQ_DEASSERT_MAX_US = 500;
  localparam int unsigned IRQ_DEASSERT_MAX_CYCLES = IRQ_DEASSERT_MAX_US * CLK_FREQ_MHZ;
  localparam int unsigned LOW_POWER_MAX_US = 200;
  localparam int unsigned LOW_POWER_MAX_CYCLES = LOW_POWER_MAX_US * CLK_FREQ_MHZ;
  localparam int unsigned RESET_CNT_W = 12;

  // Register byte offsets
  localparam logic [7:0] FLAG_OFFSET = 8'h00;
  localparam logic [7:0] MASK_OFFSET = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] CONDITION_OFFSET = 8'h10;

  // Field positions
  localparam int unsigned RX_LOS_BIT = 0;
  localparam int unsigned CTRL_FORCE_LOW_POWER_BIT = 0;
  localparam int unsigned STAT_INIT_BIT = 0;
  localparam int unsigned STAT_LOW_POWER_BIT = 1;
  localparam int unsigned STAT_IRQ_BIT = 2;
  localparam int unsigned STAT_RESET_BIT = 3;

  // Reset values
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MGMT_RESET,
    MGMT_INIT,
    MGMT_READY
  } mgmt_state_type;
endpackage

/* File: src/pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the inputs are quasi-static levels; output moves when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      level <= INIT;
    end else if (clk_en) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

/* File: bench/flag_irq_monitor.sv */
// Checker for flag, interrupt and low-power timing at the block ports.
// Assumes the master offers write address and write data together.
`timescale 1ns/1ps
`default_nettype none
module flag_irq_monitor
  import module_flag_pkg::*;
#(
  parameter int unsigned NUM_FLAGS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic module_reset_n,
  input wire logic low_power_request_n,
  input wire logic [NUM_FLAGS-1:0] flag_condition,
  input wire logic module_irq_n,
  input wire logic management_init_state,
  input wire logic low_power_mode
);
  logic [NUM_FLAGS-1:0] m;
  logic [3:0] q;
  logic wr;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Shadow of the mask and cycles since all conditions went away
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m <= '0;
      q <= '0;
    end else begin
      if (wr && s_axi_awaddr == MASK_OFFSET) begin
        m <= s_axi_wdata[NUM_FLAGS-1:0];
      end
      q <= (flag_condition != '0) ? 4'h0 : ((q == 4'hf) ? q : q + 4'h1);
    end
  end
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_init_done:
    assert property ($rose(aresetn) && module_reset_n |-> ##[1:40] !management_init_state)
    else $error("init state stuck after reset");
  a_pin_reset_init:
    assert property ($rose(module_reset_n) |-> ##[1:40] !management_init_state)
    else $error("init state stuck after pin reset");
  a_irq_raise:
    assert property ((|(flag_condition & ~$past(flag_condition) & ~m)) && !management_init_state
      |-> ##[1:8] !module_irq_n)
    else $error("interrupt not raised");
  a_irq_hold:
    assert property ((flag_condition[0] && !m[0] && !management_init_state) [*8] |-> !module_irq_n)
    else $error("interrupt released while pending");
  a_irq_release:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == FLAG_OFFSET && q >= 4'h6
      |-> ##[1:2] module_irq_n)
    else $error("interrupt not released after read");
  a_irq_masked:
    assert property ((m == '1) [*3] |-> module_irq_n)
    else $error("masked flag drives interrupt");
  a_irq_unmask:
    assert property ((|($past(m) & ~m & flag_condition)) && !management_init_state
      |-> ##[1:4] !module_irq_n)
    else $error("unmasked flag ignored");
  a_lp_pins:
    assert property ($fell(low_power_request_n) || $fell(module_reset_n) |-> ##[1:8] low_power_mode)
    else $error("low power not entered from pin");
  a_lp_force:
    assert property (wr && s_axi_awaddr == CONTROL_OFFSET && s_axi_wdata[CTRL_FORCE_LOW_POWER_BIT]
      |-> ##[1:3] low_power_mode)
    else $error("low power not entered from force bit");
  c_irq: cover property (!module_irq_n);
  c_init_end: cover property ($fell(management_init_state));
  c_force: cover property (low_power_mode && module_reset_n && low_power_request_n);
endmodule
bind module_flag_interrupt_timing flag_irq_monitor #(.NUM_FLAGS(NUM_FLAGS)) u_flag_irq_monitor (.*);
`default_nettype wire

/* File: bench/host_sideband_model.sv */
// Host model for the sideband pins: module reset pulse and low-power request.
// Assumes one-cycle reset_go strobes and a level lp_go from the bench.
`timescale 1ns/1ps
`default_nettype none
module host_sideband_model
  import module_flag_pkg::*;
(
  input wire logic aclk,
  input wire logic reset_go,
  input wire logic lp_go,
  output logic module_reset_n,
  output logic low_power_request_n
);
  int unsigned cnt = 0;
  initial begin
    module_reset_n = 1'b1;
    low_power_request_n = 1'b1;
  end
  always @(posedge aclk) begin
    if (reset_go) begin
      cnt <= RESET_MIN_CYCLES + 40;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    module_reset_n <= !reset_go && cnt == 0;
    low_power_request_n <= !lp_go;
  end
endmodule
`default_nettype wire

/* File: bench/module_flag_interrupt_timing_tb.sv */
// Self-checking bench for the flag, interrupt and low-power block.
// Assumes the host model drives the reset and low-power pins.
`timescale 1ns/1ps
`default_nettype none
module module_flag_interrupt_timing_tb;
  import module_flag_pkg::*;
  localparam int unsigned INIT = 16;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;
    logic [1:0] s;} row_type;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic module_reset_n, low_power_request_n, module_irq_n, management_init_state;
  logic low_power_mode, reset_go, lp_go;
  logic [7:0] s_axi_awaddr, s_axi_araddr, flag_condition;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, n_compared = 0, tcount = 0;
  row_type rows [9] = '{
    '{1'b1, 8'h04, 32'h0000_00a5, 32'h0, RESP_OKAY}, '{1'b0, 8'h04, 32'h0, 32'h0000_00a5, RESP_OKAY},
    '{1'b1, 8'h08, 32'h1, 32'h0, RESP_OKAY}, '{1'b0, 8'h0c, 32'h0, 32'h2, RESP_OKAY},
    '{1'b1, 8'h08, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, 8'h0c, 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, 8'h20, 32'h0, 32'h0, RESP_SLVERR}, '{1'b1, 8'h20, 32'h1, 32'h0, RESP_SLVERR},
    '{1'b1, 8'h04, 32'h0, 32'h0, RESP_OKAY}};
  module_flag_interrupt_timing #(.INIT_CYCLES(INIT)) u_module_flag_interrupt_timing (.*);
  host_sideband_model u_host_sideband_model (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready));
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    tcount <= tcount + 1;
    if (tcount == 6000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    aresetn <= 1'b0;
    clk_en <= 1'b1;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
    {flag_condition, reset_go, lp_go} <= 10'h000;
    cyc(20);
    chk({module_irq_n, management_init_state, low_power_mode}, 32'h7);
    aresetn <= 1'b1;
    cyc(INIT + 30);
    chk(management_init_state, 32'h0);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      chk(r, rows[i].s);
      if (!rows[i].w) chk(q, rows[i].e);
    end
    done("register rows");
    flag_condition <= 8'h01;
    cyc(10);
    chk(module_irq_n, 32'h0);
    flag_condition <= 8'h00;
    cyc(10);
    xfer(1'b0, FLAG_OFFSET, 32'h0);
    chk(q, 32'h1);
    cyc(4);
    chk(module_irq_n, 32'h1);
    xfer(1'b0, FLAG_OFFSET, 32'h0);
    chk(q, 32'h0);
    done("receive loss flag");
    xfer(1'b1, MASK_OFFSET, 32'hff);
    flag_condition <= 8'h02;
    cyc(10);
    chk(module_irq_n, 32'h1);
    xfer(1'b1, MASK_OFFSET, 32'h0);
    cyc(4);
    chk(module_irq_n, 32'h0);
    flag_condition <= 8'h00;
    cyc(10);
    xfer(1'b0, FLAG_OFFSET, 32'h0);
    chk(q, 32'h2);
    cyc(4);
    chk(module_irq_n, 32'h1);
    done("mask");
    lp_go <= 1'b1;
    cyc(10);
    chk(low_power_mode, 32'h1);
    lp_go <= 1'b0;
    cyc(10);
    chk(low_power_mode, 32'h0);
    reset_go <= 1'b1;
    cyc(1);
    reset_go <= 1'b0;
    cyc(10);
    chk(low_power_mode, 32'h1);
    cyc(RESET_MIN_CYCLES);
    chk(management_init_state, 32'h1);
    while (!module_reset_n) cyc(1);
    cyc(INIT + 30);
    chk({management_init_state, low_power_mode}, 32'h0);
    done("low power and pin reset");
    xfer(1'b1, MASK_OFFSET, 32'h0f);
    flag_condition <= 8'h01;
    aresetn <= 1'b0;
    cyc(4);
    chk(module_irq_n, 32'h1);
    aresetn <= 1'b1;
    cyc(INIT + 30);
    chk(module_irq_n, 32'h0);
    flag_condition <= 8'h00;
    xfer(1'b0, MASK_OFFSET, 32'h0);
    chk(q, 32'h0);
    done("reset in mid-run");
    cyc(10);
    clk_en <= 1'b0;
    cyc(3);
    chk(s_axi_arready, 32'h0);
    chk(module_irq_n, 32'h0);
    clk_en <= 1'b1;
    xfer(1'b0, FLAG_OFFSET, 32'h0);
    chk(q, 32'h1);
    cyc(4);
    chk(module_irq_n, 32'h1);
    done("clock enable freeze");
    summarize();
  end
endmodule
`default_nettype wire
